//--- src/calfsm_counter.sv
// sample counter for the measuring phase
`timescale 1ns/1ps
module calfsm_counter #(
  parameter int N = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // control
  input wire logic i_clear,
  input wire logic i_sample,
  // status
  output logic o_done
);
  localparam int W = $clog2(N + 1);
  localparam logic [W-1:0] LAST = W'(N);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (i_clear) begin
      cnt_d = '0;
    end else if (i_sample && cnt_q != LAST) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_done = (cnt_q == LAST);
endmodule

//--- src/calfsm_pkg.sv
// package: constants and types of the calibration state machine
package calfsm_pkg;
  // register addresses as printed (Modbus holding register numbers)
  localparam logic [15:0] ADDR_STATE_REQUEST = 16'h1388;
  localparam logic [15:0] ADDR_TARGET_SELECT = 16'h1389;
  localparam logic [15:0] ADDR_STATE_READBACK = 16'h138A;
  // machine number carried in the high byte of the request word
  localparam logic [7:0] MACHINE_NUMBER = 8'h01;
  // state codes reported in the readback low byte
  localparam logic [7:0] ST_ACTIVATE = 8'h00;
  localparam logic [7:0] ST_VALIDATE = 8'h01;
  localparam logic [7:0] ST_IDLE = 8'h02;
  localparam logic [7:0] ST_POINT1 = 8'h03;
  localparam logic [7:0] ST_POINT2 = 8'h04;
  localparam logic [7:0] ST_MEASURE = 8'h06;
  localparam logic [7:0] ST_TARGET = 8'h07;
  localparam logic [7:0] ST_CALC = 8'h08;
  localparam logic [7:0] ST_SAVE = 8'h09;
  localparam logic [7:0] ST_SUCCESS = 8'h0B;
  // calibration methods in the selector low byte
  localparam logic [7:0] METHOD_NONE = 8'h00;
  localparam logic [7:0] METHOD_LINEAR = 8'h01;
  // error bit positions
  localparam int ERR_BAD_METHOD = 0;
  localparam int ERR_BAD_PARAM = 1;
  localparam int ERR_TARGET = 2;
  localparam int ERR_CALC = 3;
  // reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // default sample count gathered in the measuring phase
  localparam int SAMPLES_NEEDED = 16;
  typedef enum logic [9:0] {
    S_OFF = 10'b00_0000_0001,
    S_ACTIVE = 10'b00_0000_0010,
    S_VALIDATE = 10'b00_0000_0100,
    S_IDLE = 10'b00_0000_1000,
    S_MEASURE = 10'b00_0001_0000,
    S_TARGET = 10'b00_0010_0000,
    S_CALC = 10'b00_0100_0000,
    S_SAVE = 10'b00_1000_0000,
    S_SUCCESS = 10'b01_0000_0000,
    S_SAVEACK = 10'b10_0000_0000
  } calfsm_state_t;
endpackage

//--- src/calfsm_top.sv
// calibration state machine driven by holding register writes
// Summary of operation
// - machine number 1 addresses this calibration machine in the request high byte
// - request state 0 activates machine and suspends normal measuring
// - feasible method: enter state 2, disable present coefficients of parameter
// - validation failure: stay in state 1 and set error bits
// - state 2 is idle, waiting for the next request
// - state 3 starts first point, state 4 second point, any method
// - report state 6 while measuring; host keeps triggering measurements
// - enough samples gathered: go to state 7, await setpoint
// - target accepted returns to state 2, otherwise stays in 7
// - state 8 computes coefficients, applies provisionally, discarded on exit
// - calculation success enters state 11, failure stays in state 8
// - state 9 saves: old set becomes last, new set active, persists
// - state 11 waits; host requests state 2 to continue
// - writing 0 ends machine anytime, unsaved coefficients restored
// - no internal error recovery; host must request 0 and reinitialise (here an accepted setpoint clears error bit 2 and returns to state 2)
// - method 0x00 means no calibration/reset, 0x01 linear two-point
`timescale 1ns/1ps
module calfsm_top #(
  parameter int SAMPLES = calfsm_pkg::SAMPLES_NEEDED,
  parameter int PARAM_COUNT = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // holding register access (one word per cycle)
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // measurement side
  input wire logic i_sample_valid,
  input wire logic i_target_wr,
  input wire logic i_target_ok,
  input wire logic i_calc_done,
  input wire logic i_calc_ok,
  // effects on the measuring path
  output logic o_machine_active_flag,
  output logic o_coeff_disable,
  output logic [7:0] o_coeff_param,
  output logic o_coeff_provisional,
  output logic o_coeff_restore,
  output logic o_calc_start,
  output logic o_point_sel,
  output logic o_save_pulse,
  output logic [3:0] o_error
);
  calfsm_pkg::calfsm_state_t st_q, st_d;
  logic [15:0] req_q, req_d;
  logic [15:0] sel_q, sel_d;
  logic [7:0] code_q, code_d;
  logic [3:0] err_q, err_d;
  logic dis_q, dis_d;
  logic prov_q, prov_d;
  logic rest_q, rest_d;
  logic calc_q, calc_d;
  logic pt_q, pt_d;
  logic save_q, save_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic act_q, act_d;
  logic samples_done;
  logic req_wr;
  logic sel_wr;
  logic [7:0] rq_state;
  logic rq_ours;

  assign req_wr = i_reg_wr && (i_reg_addr == calfsm_pkg::ADDR_STATE_REQUEST);
  assign sel_wr = i_reg_wr && (i_reg_addr == calfsm_pkg::ADDR_TARGET_SELECT);
  assign rq_state = i_reg_wdata[7:0];
  assign rq_ours = (i_reg_wdata[15:8] == calfsm_pkg::MACHINE_NUMBER);

  calfsm_counter #(
    .N(SAMPLES)
  ) u_samples (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(st_q != calfsm_pkg::S_MEASURE),
    .i_sample(i_sample_valid),
    .o_done(samples_done)
  );

  always_comb begin
    st_d = st_q;
    req_d = req_q;
    sel_d = sel_q;
    code_d = code_q;
    err_d = err_q;
    dis_d = dis_q;
    prov_d = prov_q;
    rest_d = 1'b0;
    calc_d = 1'b0;
    pt_d = pt_q;
    save_d = 1'b0;
    if (sel_wr) begin
      sel_d = i_reg_wdata;
    end
    if (req_wr) begin
      req_d = i_reg_wdata;
    end
    // any write of the zero word ends the machine first; a state 0 request activates it
    if (req_wr && (i_reg_wdata == calfsm_pkg::RESET_WORD)) begin
      st_d = calfsm_pkg::S_OFF;
      code_d = calfsm_pkg::ST_ACTIVATE;
      err_d = '0;
      rest_d = prov_q || dis_q;
      dis_d = 1'b0;
      prov_d = 1'b0;
    end else if (req_wr && rq_ours && rq_state == calfsm_pkg::ST_ACTIVATE) begin
      st_d = calfsm_pkg::S_ACTIVE;
      code_d = calfsm_pkg::ST_ACTIVATE;
      err_d = '0;
    end else begin
      case (st_q)
        calfsm_pkg::S_OFF: begin
          code_d = calfsm_pkg::ST_ACTIVATE;
        end
        calfsm_pkg::S_ACTIVE, calfsm_pkg::S_VALIDATE: begin
          // errors stick until state 0: no recovery inside
          if (req_wr && rq_ours && rq_state == calfsm_pkg::ST_VALIDATE && err_q == '0) begin
            if (sel_q[7:0] == calfsm_pkg::METHOD_NONE) begin
              // method none only resets the machine to state 0, it is not an error
              st_d = calfsm_pkg::S_ACTIVE;
              code_d = calfsm_pkg::ST_ACTIVATE;
            end else if (sel_q[7:0] == calfsm_pkg::METHOD_LINEAR
                && 32'(sel_q[15:8]) < PARAM_COUNT) begin
              st_d = calfsm_pkg::S_IDLE;
              code_d = calfsm_pkg::ST_IDLE;
              dis_d = 1'b1;
            end else begin
              st_d = calfsm_pkg::S_VALIDATE;
              code_d = calfsm_pkg::ST_VALIDATE;
              err_d[calfsm_pkg::ERR_BAD_METHOD] = (sel_q[7:0] != calfsm_pkg::METHOD_LINEAR);
              err_d[calfsm_pkg::ERR_BAD_PARAM] = (32'(sel_q[15:8]) >= PARAM_COUNT);
            end
          end
        end
        calfsm_pkg::S_IDLE: begin
          code_d = calfsm_pkg::ST_IDLE;
          if (req_wr && rq_ours) begin
            case (rq_state)
              calfsm_pkg::ST_POINT1, calfsm_pkg::ST_POINT2: begin
                st_d = calfsm_pkg::S_MEASURE;
                code_d = calfsm_pkg::ST_MEASURE;
                pt_d = (rq_state == calfsm_pkg::ST_POINT2);
              end
              calfsm_pkg::ST_CALC: begin
                st_d = calfsm_pkg::S_CALC;
                code_d = calfsm_pkg::ST_CALC;
                calc_d = 1'b1;
              end
              calfsm_pkg::ST_SAVE: begin
                if (prov_q) begin
                  st_d = calfsm_pkg::S_SAVE;
                  code_d = calfsm_pkg::ST_SAVE;
                end
              end
              default: begin
              end
            endcase
          end
        end
        calfsm_pkg::S_MEASURE: begin
          if (samples_done) begin
            st_d = calfsm_pkg::S_TARGET;
            code_d = calfsm_pkg::ST_TARGET;
          end
        end
        calfsm_pkg::S_TARGET: begin
          if (i_target_wr) begin
            if (i_target_ok) begin
              st_d = calfsm_pkg::S_IDLE;
              code_d = calfsm_pkg::ST_IDLE;
              err_d[calfsm_pkg::ERR_TARGET] = 1'b0;
            end else begin
              err_d[calfsm_pkg::ERR_TARGET] = 1'b1;
            end
          end
        end
        calfsm_pkg::S_CALC: begin
          if (i_calc_done) begin
            if (i_calc_ok) begin
              st_d = calfsm_pkg::S_SUCCESS;
              code_d = calfsm_pkg::ST_SUCCESS;
              prov_d = 1'b1;
            end else begin
              err_d[calfsm_pkg::ERR_CALC] = 1'b1;
            end
          end
        end
        calfsm_pkg::S_SAVE: begin
          save_d = 1'b1;
          prov_d = 1'b0;
          dis_d = 1'b0;
          st_d = calfsm_pkg::S_SAVEACK;
          code_d = calfsm_pkg::ST_SUCCESS;
        end
        calfsm_pkg::S_SUCCESS, calfsm_pkg::S_SAVEACK: begin
          if (req_wr && rq_ours && rq_state == calfsm_pkg::ST_IDLE) begin
            st_d = calfsm_pkg::S_IDLE;
            code_d = calfsm_pkg::ST_IDLE;
          end
        end
        default: begin
          st_d = calfsm_pkg::S_OFF;
          code_d = calfsm_pkg::ST_ACTIVATE;
        end
      endcase
    end
    act_d = (st_d != calfsm_pkg::S_OFF);
  end

  always_comb begin
    rvalid_d = i_reg_rd;
    rdata_d = '0;
    case (i_reg_addr)
      calfsm_pkg::ADDR_STATE_REQUEST: rdata_d = req_q;
      calfsm_pkg::ADDR_TARGET_SELECT: rdata_d = sel_q;
      calfsm_pkg::ADDR_STATE_READBACK: rdata_d = {7'h00, st_q != calfsm_pkg::S_OFF, code_q};
      default: rdata_d = '0;
    endcase
    if (!i_reg_rd) begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= calfsm_pkg::S_OFF;
      req_q <= calfsm_pkg::RESET_WORD;
      sel_q <= calfsm_pkg::RESET_WORD;
      code_q <= calfsm_pkg::ST_ACTIVATE;
      err_q <= '0;
      dis_q <= 1'b0;
      prov_q <= 1'b0;
      rest_q <= 1'b0;
      calc_q <= 1'b0;
      pt_q <= 1'b0;
      save_q <= 1'b0;
      rdata_q <= calfsm_pkg::RESET_WORD;
      rvalid_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      sel_q <= sel_d;
      code_q <= code_d;
      err_q <= err_d;
      dis_q <= dis_d;
      prov_q <= prov_d;
      rest_q <= rest_d;
      calc_q <= calc_d;
      pt_q <= pt_d;
      save_q <= save_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      act_q <= act_d;
    end
  end

  assign o_machine_active_flag = act_q;
  assign o_coeff_disable = dis_q;
  assign o_coeff_param = sel_q[15:8];
  assign o_coeff_provisional = prov_q;
  assign o_coeff_restore = rest_q;
  assign o_calc_start = calc_q;
  assign o_point_sel = pt_q;
  assign o_save_pulse = save_q;
  assign o_error = err_q;
  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  a_abort_ends: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (req_wr && i_reg_wdata == 16'h0000) |=> (st_q == calfsm_pkg::S_OFF && code_q == 8'h00))
    else $error("zero request did not end machine");
  a_restore_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (req_wr && i_reg_wdata == 16'h0000 && prov_q) |=> rest_q && !prov_q)
    else $error("provisional set not discarded");
  a_valid_ok: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == calfsm_pkg::S_ACTIVE && req_wr && i_reg_wdata == 16'h0101 && err_q == 0
     && sel_q[7:0] == 8'h01 && sel_q[15:8] == 8'h00) |=> (code_q == 8'h02 && dis_q))
    else $error("valid selection did not reach idle");
  a_valid_bad: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == calfsm_pkg::S_ACTIVE && req_wr && i_reg_wdata == 16'h0101
     && sel_q[7:0] != 8'h01 && sel_q[7:0] != 8'h00) |=> (code_q == 8'h01 && err_q[0]))
    else $error("bad method not flagged");
  a_method_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == calfsm_pkg::S_ACTIVE && req_wr && i_reg_wdata == 16'h0101 && sel_q[7:0] == 8'h00)
    |=> (st_q == calfsm_pkg::S_ACTIVE && code_q == 8'h00 && o_machine_active_flag))
    else $error("method none did not reset machine");
  a_active_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_machine_active_flag == (st_q != calfsm_pkg::S_OFF))
    else $error("active flag out of step with state");
  a_point_meas: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == calfsm_pkg::S_IDLE && req_wr && (i_reg_wdata == 16'h0103
     || i_reg_wdata == 16'h0104)) |=> code_q == 8'h06)
    else $error("point request did not start measuring");
  a_meas_target: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == calfsm_pkg::S_MEASURE && samples_done && !req_wr) |=> code_q == 8'h07)
    else $error("samples gathered but no target wait");
  a_target_stay: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == calfsm_pkg::S_TARGET && i_target_wr && !i_target_ok && !req_wr)
    |=> (code_q == 8'h07)[*1] ##0 err_q[2])
    else $error("rejected target left state 7");
  a_calc_ok: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == calfsm_pkg::S_CALC && i_calc_done && i_calc_ok && !req_wr)
    |=> (code_q == 8'h0B && prov_q))
    else $error("calculation success not reported");
  a_save_seq: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == calfsm_pkg::S_SAVE && !req_wr) |=> save_q ##1 !save_q)
    else $error("save pulse wrong");
endmodule

//--- tb/calfsm_host.sv
// host model: holding register master and measuring-side events
`timescale 1ns/1ps
module calfsm_host (
  // clock
  input wire logic i_clk,
  // register access
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [15:0] o_reg_addr,
  output logic [15:0] o_reg_wdata,
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  // measuring side
  output logic o_sample_valid,
  output logic o_target_wr,
  output logic o_target_ok,
  output logic o_calc_done,
  output logic o_calc_ok
);
  initial begin
    {o_reg_wr, o_reg_rd, o_sample_valid, o_target_wr, o_target_ok} = 5'h00;
    {o_calc_done, o_calc_ok} = 2'h0;
    o_reg_addr = 16'h0000;
    o_reg_wdata = 16'h0000;
  end
  // single-register write, one word per pulse
  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(negedge i_clk);
    o_reg_wr = 1'b1;
    o_reg_addr = addr;
    o_reg_wdata = data;
    @(negedge i_clk);
    o_reg_wr = 1'b0;
    // released lines must not keep the last word
    o_reg_wdata = ~data;
  endtask
  // read of one register
  task automatic rd(input logic [15:0] addr, output logic [15:0] data);
    @(negedge i_clk);
    o_reg_rd = 1'b1;
    o_reg_addr = addr;
    @(negedge i_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~addr;
    data = i_reg_rvalid ? i_reg_rdata : 16'hxxxx;
  endtask
  // activate, select, then initialise
  task automatic start_cal(input logic [15:0] sel);
    wr(16'h1388, 16'h0100);
    wr(16'h1389, sel);
    wr(16'h1388, 16'h0101);
  endtask
  // trigger n measurements, one sample pulse every two cycles
  task automatic samples(input int n);
    repeat (n) begin
      @(negedge i_clk);
      o_sample_valid = 1'b1;
      @(negedge i_clk);
      o_sample_valid = 1'b0;
    end
  endtask
  // setpoint written (calc 0) or calculation finished (calc 1)
  task automatic result(input logic calc, input logic ok);
    @(negedge i_clk);
    o_target_wr = ~calc;
    o_calc_done = calc;
    {o_target_ok, o_calc_ok} = {ok, ok};
    @(negedge i_clk);
    {o_target_wr, o_calc_done} = 2'h0;
    {o_target_ok, o_calc_ok} = {~ok, ~ok};
  endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the calibration state machine
`timescale 1ns/1ps
module testbench;
  localparam int SAMP = 2;
  localparam logic [15:0] REQ = calfsm_pkg::ADDR_STATE_REQUEST;
  logic i_clk, i_reset_n, i_reg_wr, i_reg_rd, i_sample_valid;
  logic i_target_wr, i_target_ok, i_calc_done, i_calc_ok;
  logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic o_reg_rvalid, o_machine_active_flag, o_coeff_disable, o_coeff_provisional;
  logic o_coeff_restore, o_calc_start, o_point_sel, o_save_pulse;
  logic [7:0] o_coeff_param;
  logic [3:0] o_error;
  int fail_count, checks, cycles, n_save, n_restore, n_calc, s0;
  calfsm_top #(.SAMPLES(SAMP)) calfsm_top_i (
    .i_clk, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rvalid, .i_sample_valid, .i_target_wr, .i_target_ok,
    .i_calc_done, .i_calc_ok, .o_machine_active_flag, .o_coeff_disable,
    .o_coeff_param, .o_coeff_provisional, .o_coeff_restore, .o_calc_start,
    .o_point_sel, .o_save_pulse, .o_error);
  calfsm_host calfsm_host_i (
    .i_clk, .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr),
    .o_reg_wdata(i_reg_wdata), .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
    .o_sample_valid(i_sample_valid), .o_target_wr(i_target_wr),
    .o_target_ok(i_target_ok), .o_calc_done(i_calc_done), .o_calc_ok(i_calc_ok));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // pulses counted at the falling edge, where they have settled
  always @(negedge i_clk) begin
    cycles++;
    if (o_save_pulse === 1'b1) n_save++;
    if (o_coeff_restore === 1'b1) n_restore++;
    if (o_calc_start === 1'b1) n_calc++;
    if (cycles == 20000) begin
      fail_count++;
      $display("unexpected at %0t: run hung", $time);
      close_out();
    end
  end
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic state_is(input logic [15:0] exp);
    logic [15:0] got;
    calfsm_host_i.rd(calfsm_pkg::ADDR_STATE_READBACK, got);
    cmp_word(got, exp, "readback");
  endtask
  task automatic t_activate();
    state_is(16'h0000);
    calfsm_host_i.wr(REQ, 16'h0200);
    state_is(16'h0000);
    calfsm_host_i.wr(REQ, 16'h0100);
    state_is(16'h0100);
    cmp_flag(o_machine_active_flag, 1'b1, "active");
    calfsm_host_i.wr(REQ, 16'h0000);
    state_is(16'h0000);
    cmp_flag(o_machine_active_flag, 1'b0, "inactive");
    $display("test activate done");
  endtask
  task automatic t_bad_select();
    logic [15:0] sel [2] = '{16'h0005, 16'h0201};
    logic [3:0] err [2] = '{4'h1, 4'h2};
    for (int k = 0; k < 2; k++) begin
      calfsm_host_i.start_cal(sel[k]);
      state_is(16'h0101);
      cmp_word({12'h000, o_error}, {12'h000, err[k]}, "errors");
      cmp_flag(o_coeff_disable, 1'b0, "coeff kept");
      calfsm_host_i.wr(REQ, 16'h0000);
      state_is(16'h0000);
    end
    calfsm_host_i.start_cal(16'h0000);
    state_is(16'h0100);
    cmp_word({12'h000, o_error}, 16'h0000, "method none");
    calfsm_host_i.wr(REQ, 16'h0000);
    state_is(16'h0000);
    $display("test bad selection done");
  endtask
  task automatic t_ph_flow();
    calfsm_host_i.start_cal(16'h0001);
    state_is(16'h0102);
    cmp_flag(o_coeff_disable, 1'b1, "coeff off");
    cmp_word({8'h00, o_coeff_param}, 16'h0000, "param");
    cmp_word({12'h000, o_error}, 16'h0000, "errors cleared");
    for (int p = 0; p < 2; p++) begin
      calfsm_host_i.wr(REQ, 16'h0103 + 16'(p));
      state_is(16'h0106);
      cmp_flag(o_point_sel, p[0], "point");
      calfsm_host_i.samples(SAMP - 1);
      state_is(16'h0106);
      calfsm_host_i.samples(1);
      state_is(16'h0107);
      calfsm_host_i.result(1'b0, 1'b1);
      state_is(16'h0102);
    end
    s0 = n_calc;
    calfsm_host_i.wr(REQ, 16'h0108);
    state_is(16'h0108);
    cmp_word(16'(n_calc - s0), 16'h0001, "calc start");
    calfsm_host_i.result(1'b1, 1'b1);
    state_is(16'h010B);
    cmp_flag(o_coeff_provisional, 1'b1, "provisional");
    calfsm_host_i.wr(REQ, 16'h0102);
    state_is(16'h0102);
    s0 = n_save;
    calfsm_host_i.wr(REQ, 16'h0109);
    state_is(16'h010B);
    cmp_word(16'(n_save - s0), 16'h0001, "save");
    calfsm_host_i.wr(REQ, 16'h0102);
    state_is(16'h0102);
    s0 = n_restore;
    calfsm_host_i.wr(REQ, 16'h0000);
    state_is(16'h0000);
    cmp_word(16'(n_restore - s0), 16'h0000, "saved set kept");
    $display("test ph flow done");
  endtask
  task automatic t_failures();
    calfsm_host_i.start_cal(16'h0101);
    state_is(16'h0102);
    cmp_word({8'h00, o_coeff_param}, 16'h0001, "param");
    calfsm_host_i.wr(REQ, 16'h0109);
    state_is(16'h0102);
    calfsm_host_i.wr(REQ, 16'h0103);
    calfsm_host_i.samples(SAMP);
    calfsm_host_i.result(1'b0, 1'b0);
    state_is(16'h0107);
    cmp_word({12'h000, o_error}, 16'h0004, "target error");
    calfsm_host_i.wr(REQ, 16'h0000);
    calfsm_host_i.start_cal(16'h0001);
    calfsm_host_i.wr(REQ, 16'h0108);
    calfsm_host_i.result(1'b1, 1'b0);
    state_is(16'h0108);
    cmp_word({12'h000, o_error}, 16'h0008, "calc error");
    calfsm_host_i.wr(REQ, 16'h0000);
    calfsm_host_i.start_cal(16'h0001);
    calfsm_host_i.wr(REQ, 16'h0108);
    calfsm_host_i.result(1'b1, 1'b1);
    state_is(16'h010B);
    s0 = n_restore;
    calfsm_host_i.wr(REQ, 16'h0000);
    state_is(16'h0000);
    cmp_word(16'(n_restore - s0), 16'h0001, "restore");
    cmp_flag(o_coeff_provisional, 1'b0, "discarded");
    $display("test failures done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {fail_count, checks, cycles, n_save, n_restore, n_calc} = '0;
    i_reset_n = 1'b0;
    repeat (20) @(negedge i_clk);
    i_reset_n = 1'b1;
    t_activate();
    t_bad_select();
    t_ph_flow();
    t_failures();
    close_out();
  end
endmodule
